// file: hdl/flash_sr1_pkg.sv
// Purpose : Shared constants and types for the first volatile status register block.
// Assumes : Mode 0 or mode 3 serial framing, most significant bit first.
// Notes   : Opcodes without a fixed value elsewhere are plain defaults.
package flash_sr1_pkg;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {KIND_REG, KIND_OTHER, KIND_PROG, KIND_ERASE} op_kind_e;
	typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BUSY} state_e;

	// ------------------------------------------------------------------
	// Command opcodes
	// ------------------------------------------------------------------
	localparam byte_t OP_WRITE_ENABLE     = 8'h06;
	localparam byte_t OP_VOL_WRITE_ENABLE = 8'h50;
	localparam byte_t OP_WRITE_DISABLE    = 8'h04;
	localparam byte_t OP_CLEAR_STATUS     = 8'h30;
	localparam byte_t OP_REGISTER_WRITE   = 8'h01;
	localparam byte_t OP_ANY_REG_WRITE    = 8'h71;
	localparam byte_t OP_STATUS_READ_ONE  = 8'h05;
	localparam byte_t OP_STATUS_READ_TWO  = 8'h07;
	localparam byte_t OP_ANY_REG_READ     = 8'h65;
	localparam byte_t OP_SUSPEND          = 8'h75;
	localparam byte_t OP_RESUME           = 8'h7A;
	localparam byte_t OP_RESET_ARM        = 8'h66;
	localparam byte_t OP_RESET_GO         = 8'h99;
	localparam byte_t OP_PAGE_PROGRAM     = 8'h02;
	localparam byte_t OP_SECTOR_ERASE     = 8'h20;

	// ------------------------------------------------------------------
	// Register layout and frame lengths
	// ------------------------------------------------------------------
	localparam int          BIT_LOCK    = 7;
	localparam int          BIT_GRAN    = 6;
	localparam int          BIT_ORIGIN  = 5;
	localparam int          BIT_BP_HI   = 4;
	localparam int          BIT_BP_LO   = 2;
	localparam int          BIT_WEL     = 1;
	localparam logic [23:0] STATUS_ONE_VOLATILE_ADDR = 24'h800000;
	localparam logic [5:0]  CNT_OPCODE   = 6'h08;
	localparam logic [5:0]  CNT_ONE_BYTE = 6'h10;
	localparam logic [5:0]  CNT_TWO_BYTE = 6'h18;
	localparam logic [5:0]  CNT_ADDR     = 6'h20;
	localparam logic [5:0]  CNT_ADDR_DAT = 6'h28;
	localparam logic [5:0]  CNT_MAX      = 6'h3F;
	localparam logic [2:0]  BIT_TOP      = 3'h7;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int         MCLK_PERIOD_NS = 40;
	localparam int         OP_TIME_NS     = 1000;
	localparam int         OP_CYCLES_INT  = (OP_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
	localparam logic [7:0] OP_CYCLES      = 8'(OP_CYCLES_INT);
	localparam logic [7:0] TMR_LAST       = 8'h01;

	// Commands that stay accepted while an operation is running.
	function automatic logic busy_ok(input byte_t op);
		busy_ok = (op == OP_STATUS_READ_ONE) || (op == OP_STATUS_READ_TWO) ||
		          (op == OP_ANY_REG_READ) || (op == OP_SUSPEND) ||
		          (op == OP_CLEAR_STATUS) || (op == OP_RESET_ARM) || (op == OP_RESET_GO);
	endfunction : busy_ok

endpackage : flash_sr1_pkg

// file: hdl/status_reg_protect_and_busy.sv
// Purpose : First volatile status register with write protection, write latch and busy.
// Assumes : Host keeps chip select high for at least five master clocks between frames.
// Notes   : Link logic runs on the serial clock; frame words are read once the
//           synchronised chip select shows the frame has ended and the clock stands.
`timescale 1ns/10ps

module status_reg_protect_and_busy (
	// Clocks and reset
	input  wire logic                     i_mclk,
	input  wire logic                     i_rst,
	input  wire logic                     i_spi_sck,
	// Serial link pins
	input  wire logic                     i_cs_n,
	input  wire logic                     i_mosi,
	output logic                          o_miso,
	output logic                          o_miso_oe,
	input  wire logic                     i_wp_n,
	// Configuration and defaults from neighbouring registers
	input  wire logic                     i_quad_cmd_mode,
	input  wire logic                     i_quad_io_mode,
	input  wire flash_sr1_pkg::byte_t     i_status_one_defaults,
	// Array engine answers
	input  wire logic                     i_target_protected,
	input  wire logic                     i_op_fail,
	// Status and protection outputs
	output flash_sr1_pkg::byte_t          o_status_one_volatile,
	output logic                          o_protect_granularity_select,
	output logic                          o_protect_origin_select,
	output logic [2:0]                    o_legacy_range_bits,
	output logic                          o_op_start,
	output flash_sr1_pkg::op_kind_e       o_op_kind,
	output logic                          o_erase_err,
	output logic                          o_program_err,
	output logic                          o_suspended
);
	import flash_sr1_pkg::*;

	// ------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [5:0]  cnt;
		logic [2:0]  bitc;
		byte_t       op;
		logic [31:0] sr;
	} link_s;

	typedef struct packed {
		logic miso;
		logic oe;
	} out_s;

	typedef struct packed {
		state_e      st;
		logic [2:0]  cs_s;
		logic        cs_lvl;
		logic [2:0]  wp_s;
		logic        wp_lvl;
		byte_t       nv_prev;
		logic        lock;
		logic        gran;
		logic        origin;
		logic [2:0]  bp;
		logic        write_enable_latch;
		logic        operation_in_progress;
		logic        err_e;
		logic        err_p;
		logic        susp;
		op_kind_e    kind;
		logic [7:0]  tmr;
		byte_t       data;
		logic        arm;
		logic        start;
		logic [15:0] snap;
	} core_s;

	link_s ln_r, ln_nxt;
	out_s  ou_r, ou_nxt;
	core_s s_r, s_nxt;
	logic  in_frame_r;
	logic  frame_idle;
	logic  fend;
	logic  prot;
	logic  allowed;

	// ------------------------------------------------------------------
	// Link domain
	// ------------------------------------------------------------------
	// Chip select high clears the frame marker so the next edge restarts counting.
	assign frame_idle = i_rst | i_cs_n;

	always_ff @(posedge i_spi_sck or posedge frame_idle) begin
		if (frame_idle) begin
			in_frame_r <= 1'b0;
		end else begin
			in_frame_r <= 1'b1;
		end
	end

	// Shift the frame in; counts and words hold after the frame for the core.
	always_comb begin
		ln_nxt = ln_r;
		ln_nxt.sr = {ln_r.sr[30:0], i_mosi};
		if (!in_frame_r) begin
			ln_nxt.cnt  = 6'h01;
			ln_nxt.bitc = 3'h1;
			ln_nxt.sr   = {31'h0, i_mosi};
		end else begin
			ln_nxt.bitc = ln_r.bitc + 3'h1;
			if (ln_r.cnt != CNT_MAX) begin
				ln_nxt.cnt = ln_r.cnt + 6'h01;
			end
			if (ln_r.cnt == CNT_OPCODE - 6'h01) begin
				ln_nxt.op = {ln_r.sr[6:0], i_mosi};
			end
		end
	end

	always_ff @(posedge i_spi_sck or posedge i_rst) begin
		if (i_rst) begin
			ln_r <= '0;
		end else begin
			ln_r <= ln_nxt;
		end
	end

	// Read data leaves on the falling edge, most significant bit first, repeating.
	always_comb begin
		ou_nxt      = ou_r;
		ou_nxt.oe   = 1'b0;
		ou_nxt.miso = 1'b0;
		if (in_frame_r && (ln_r.cnt >= CNT_OPCODE)) begin
			if (ln_r.op == OP_STATUS_READ_ONE) begin
				ou_nxt.oe   = 1'b1;
				ou_nxt.miso = s_r.snap[15 - 32'(ln_r.bitc)];
			end else if (ln_r.op == OP_STATUS_READ_TWO) begin
				ou_nxt.oe   = 1'b1;
				ou_nxt.miso = s_r.snap[BIT_TOP - ln_r.bitc];
			end
		end
	end

	always_ff @(negedge i_spi_sck or posedge frame_idle) begin
		if (frame_idle) begin
			ou_r <= '0;
		end else begin
			ou_r <= ou_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Core domain
	// ------------------------------------------------------------------
	// Frame end: synchronised chip select turns stable high.
	assign fend = !s_r.cs_lvl && (s_r.cs_s[1] == s_r.cs_s[2]) && s_r.cs_s[2];
	// Quad modes reuse the protect pin as data, so its level counts as high.
	assign prot = s_r.lock && !(s_r.wp_lvl || i_quad_cmd_mode || i_quad_io_mode);
	assign allowed = (s_r.st == ST_IDLE) || busy_ok(ln_r.op) ||
	                 (s_r.susp && (ln_r.op == OP_RESUME));

	// Command decode, operation timer and default tracking.
	always_comb begin
		s_nxt        = s_r;
		s_nxt.start  = 1'b0;
		s_nxt.cs_s   = {s_r.cs_s[1:0], i_cs_n};
		s_nxt.wp_s   = {s_r.wp_s[1:0], i_wp_n};
		s_nxt.nv_prev = i_status_one_defaults;
		if (s_r.cs_s[1] == s_r.cs_s[2]) begin
			s_nxt.cs_lvl = s_r.cs_s[2];
		end
		if (s_r.wp_s[1] == s_r.wp_s[2]) begin
			s_nxt.wp_lvl = s_r.wp_s[2];
		end
		case (s_r.st)
			ST_LOAD: begin
				s_nxt.lock   = i_status_one_defaults[BIT_LOCK];
				s_nxt.gran   = i_status_one_defaults[BIT_GRAN];
				s_nxt.origin = i_status_one_defaults[BIT_ORIGIN];
				s_nxt.bp     = i_status_one_defaults[BIT_BP_HI:BIT_BP_LO];
				s_nxt.write_enable_latch    = i_status_one_defaults[BIT_WEL];
				s_nxt.err_e  = 1'b0;
				s_nxt.err_p  = 1'b0;
				s_nxt.susp   = 1'b0;
				s_nxt.arm    = 1'b0;
				s_nxt.st     = ST_IDLE;
			end
			ST_IDLE, ST_BUSY: begin
				if (fend) begin
					s_nxt.arm = 1'b0;
				end
				if (fend && allowed) begin
					case (ln_r.op)
						OP_WRITE_ENABLE, OP_VOL_WRITE_ENABLE: begin
							s_nxt.write_enable_latch = 1'b1;
						end
						OP_WRITE_DISABLE: begin
							s_nxt.write_enable_latch = 1'b0;
						end
						OP_CLEAR_STATUS: begin
							s_nxt.write_enable_latch   = 1'b0;
							s_nxt.err_e = 1'b0;
							s_nxt.err_p = 1'b0;
							if (s_r.err_e || s_r.err_p) begin
								s_nxt.st = ST_IDLE;
							end
						end
						OP_REGISTER_WRITE: begin
							// A refused write starts nothing and changes nothing.
							if (s_r.write_enable_latch && !prot && ((ln_r.cnt == CNT_ONE_BYTE) ||
							    (ln_r.cnt == CNT_TWO_BYTE))) begin
								s_nxt.st    = ST_BUSY;
								s_nxt.kind  = KIND_REG;
								s_nxt.tmr   = OP_CYCLES;
								s_nxt.start = 1'b1;
								s_nxt.data  = (ln_r.cnt == CNT_TWO_BYTE) ? ln_r.sr[15:8] :
								              ln_r.sr[7:0];
							end
						end
						OP_ANY_REG_WRITE: begin
							if (s_r.write_enable_latch && (ln_r.cnt == CNT_ADDR_DAT)) begin
								if (ln_r.sr[31:8] != STATUS_ONE_VOLATILE_ADDR) begin
									s_nxt.st    = ST_BUSY;
									s_nxt.kind  = KIND_OTHER;
									s_nxt.tmr   = OP_CYCLES;
									s_nxt.start = 1'b1;
								end else if (!prot) begin
									s_nxt.st    = ST_BUSY;
									s_nxt.kind  = KIND_REG;
									s_nxt.tmr   = OP_CYCLES;
									s_nxt.start = 1'b1;
									s_nxt.data  = ln_r.sr[7:0];
								end
							end
						end
						OP_PAGE_PROGRAM, OP_SECTOR_ERASE: begin
							if (s_r.write_enable_latch && (((ln_r.op == OP_PAGE_PROGRAM) &&
							    (ln_r.cnt >= CNT_ADDR_DAT)) ||
							    ((ln_r.op == OP_SECTOR_ERASE) && (ln_r.cnt == CNT_ADDR)))) begin
								s_nxt.st    = ST_BUSY;
								s_nxt.kind  = (ln_r.op == OP_PAGE_PROGRAM) ? KIND_PROG : KIND_ERASE;
								s_nxt.tmr   = OP_CYCLES;
								s_nxt.start = 1'b1;
							end
						end
						OP_SUSPEND: begin
							if ((s_r.st == ST_BUSY) && !s_r.err_e && !s_r.err_p &&
							    ((s_r.kind == KIND_PROG) || (s_r.kind == KIND_ERASE))) begin
								s_nxt.susp = 1'b1;
							end
						end
						OP_RESUME: begin
							s_nxt.susp = 1'b0;
						end
						OP_RESET_ARM: begin
							s_nxt.arm = 1'b1;
						end
						OP_RESET_GO: begin
							if (s_r.arm) begin
								s_nxt.st = ST_LOAD;
							end
						end
						default: begin
						end
					endcase
				end
				// Operation end is applied after clear-status, so a new error wins.
				if ((s_r.st == ST_BUSY) && (s_nxt.st == ST_BUSY) && !s_r.susp &&
				    !s_r.err_e && !s_r.err_p) begin
					if (s_r.tmr != TMR_LAST) begin
						s_nxt.tmr = s_r.tmr - 8'h01;
					end else begin
						case (s_r.kind)
							KIND_REG: begin
								// Only bits 7 to 2 take data; latch and busy stay hardware owned.
								s_nxt.lock   = s_r.data[BIT_LOCK];
								s_nxt.gran   = s_r.data[BIT_GRAN];
								s_nxt.origin = s_r.data[BIT_ORIGIN];
								s_nxt.bp     = s_r.data[BIT_BP_HI:BIT_BP_LO];
								s_nxt.write_enable_latch    = 1'b0;
								s_nxt.st     = ST_IDLE;
							end
							KIND_PROG: begin
								if (i_op_fail) begin
									s_nxt.err_p = 1'b1;
								end else begin
									s_nxt.write_enable_latch = 1'b0;
									s_nxt.st  = ST_IDLE;
								end
							end
							KIND_ERASE: begin
								if (i_op_fail || i_target_protected) begin
									s_nxt.err_e = 1'b1;
								end else begin
									s_nxt.write_enable_latch = 1'b0;
									s_nxt.st  = ST_IDLE;
								end
							end
							default: begin
								s_nxt.write_enable_latch = 1'b0;
								s_nxt.st  = ST_IDLE;
							end
						endcase
					end
				end
				// The lock and origin copies follow any change of their non-volatile defaults.
				if (i_status_one_defaults[BIT_LOCK] != s_r.nv_prev[BIT_LOCK]) begin
					s_nxt.lock = i_status_one_defaults[BIT_LOCK];
				end
				if (i_status_one_defaults[BIT_ORIGIN] != s_r.nv_prev[BIT_ORIGIN]) begin
					s_nxt.origin = i_status_one_defaults[BIT_ORIGIN];
				end
			end
			default: begin
				s_nxt.st = ST_LOAD;
			end
		endcase
		// Busy shows any running, loading or failed operation; zero in standby and while suspended.
		s_nxt.operation_in_progress = (s_nxt.st != ST_IDLE) && !s_nxt.susp;
		// Publish a snapshot for the link only while no frame is running.
		if (s_r.cs_s[2] && s_r.cs_lvl) begin
			s_nxt.snap = {s_r.lock, s_r.gran, s_r.origin, s_r.bp, s_r.write_enable_latch, s_r.operation_in_progress,
			              1'b0, s_r.err_e, s_r.err_p, 3'h0,
			              s_r.susp && (s_r.kind == KIND_ERASE),
			              s_r.susp && (s_r.kind == KIND_PROG)};
		end
	end

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			s_r        <= '0;
			s_r.st     <= ST_LOAD;
			s_r.cs_s   <= 3'h7;
			s_r.cs_lvl <= 1'b1;
			s_r.wp_s   <= 3'h7;
			s_r.wp_lvl <= 1'b1;
			s_r.operation_in_progress    <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Protection fields drive the range decode outside this block.
	assign o_status_one_volatile        = {s_r.lock, s_r.gran, s_r.origin, s_r.bp,
	                                       s_r.write_enable_latch, s_r.operation_in_progress};
	assign o_protect_granularity_select = s_r.gran;
	assign o_protect_origin_select      = s_r.origin;
	assign o_legacy_range_bits          = s_r.bp;
	assign o_op_start                   = s_r.start;
	assign o_op_kind                    = s_r.kind;
	assign o_erase_err                  = s_r.err_e;
	assign o_program_err                = s_r.err_p;
	assign o_suspended                  = s_r.susp;
	assign o_miso                       = ou_r.miso;
	assign o_miso_oe                    = ou_r.oe;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// Cycles that a refused register write is watched for, one full operation time.
	localparam int LOCK_HOLD_CYCLES = OP_CYCLES_INT;

	a_write_enable_cmd_sets_wel: assert property (fend && allowed && (ln_r.op == OP_WRITE_ENABLE) |=> s_r.write_enable_latch)
		else $error("write enable did not set latch");
	a_write_disable_cmd_clears_wel: assert property (fend && allowed && (ln_r.op == OP_WRITE_DISABLE) |=> !s_r.write_enable_latch)
		else $error("write disable did not clear latch");
	a_start_needs_wel: assert property ($rose(s_r.st == ST_BUSY) |-> $past(s_r.write_enable_latch))
		else $error("operation started without latch");
	a_lock_blocks_write: assert property (fend && prot && (s_r.st == ST_IDLE) &&
		(ln_r.op == OP_REGISTER_WRITE) |=> (s_r.st == ST_IDLE) && !s_r.operation_in_progress ##LOCK_HOLD_CYCLES
		$stable(s_r.bp))
		else $error("protected register write was executed");
	a_free_write_runs: assert property (fend && !s_r.lock && s_r.write_enable_latch && (s_r.st == ST_IDLE) &&
		(ln_r.op == OP_REGISTER_WRITE) && (ln_r.cnt == CNT_ONE_BYTE) |=> s_r.operation_in_progress)
		else $error("unprotected register write refused");
	a_quad_unlocks: assert property ((i_quad_cmd_mode || i_quad_io_mode) |-> !prot)
		else $error("quad mode left protection active");
	a_busy_ignores_write_enable_cmd: assert property (fend && (s_r.st == ST_BUSY) && !s_r.susp &&
		(s_r.tmr != TMR_LAST) &&
		(ln_r.op == OP_WRITE_ENABLE) |=> $stable(s_r.write_enable_latch))
		else $error("write enable accepted while busy");
	a_err_keeps_busy: assert property ((s_r.err_e || s_r.err_p) && !(fend && allowed &&
		(ln_r.op == OP_CLEAR_STATUS)) |=> s_r.operation_in_progress)
		else $error("error flag without busy");
	a_reg_end_clears: assert property ((s_r.st == ST_BUSY) && (s_r.kind == KIND_REG) &&
		!s_r.susp && (s_r.tmr == TMR_LAST) && !fend |=> !s_r.write_enable_latch && !s_r.operation_in_progress ##1 !s_r.operation_in_progress)
		else $error("register write end left latch or busy");
	a_track_lock: assert property ((s_r.st != ST_LOAD) &&
		(i_status_one_defaults[BIT_LOCK] != s_r.nv_prev[BIT_LOCK]) |=>
		(s_r.lock == $past(i_status_one_defaults[BIT_LOCK])))
		else $error("lock bit did not follow default");
	a_suspend_legal: assert property ($rose(s_r.susp) |-> $past(s_r.st == ST_BUSY) &&
		(s_r.kind == KIND_PROG || s_r.kind == KIND_ERASE))
		else $error("suspend outside program or erase");

	c_reg_write: cover property ($rose(s_r.st == ST_BUSY) && (s_r.kind == KIND_REG));
	c_erase_err: cover property ($rose(s_r.err_e));
	c_suspend:   cover property ($rose(s_r.susp));
	c_soft_reset: cover property (fend && s_r.arm && (ln_r.op == OP_RESET_GO));

endmodule : status_reg_protect_and_busy

// file: test/spi_host_model.sv
// Purpose : Host serial controller that frames commands for the status register block.
// Assumes : Mode 0 framing, most significant bit first, serial clock of 32 ns.
// Notes   : The serial clock stands low between frames; a gap follows every frame.
`timescale 1ns/10ps

module spi_host_model #(
	parameter int GAP_NS = 240
) (
	// Serial link pins
	input  wire logic i_miso,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_mosi
);

	// Idle levels before the first frame.
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_mosi = 1'b0;
	end

	// Shifts n bits of d out and captures the byte that follows the opcode.
	task automatic xfer(input logic [39:0] d, input int n, output logic [7:0] rd);
		rd     = 8'h00;
		o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_mosi = d[39 - i];
			#16 o_sck = 1'b1;
			if (i >= 8 && i < 16) begin
				rd = {rd[6:0], i_miso};
			end
			#16 o_sck = 1'b0;
		end
		#16 o_cs_n = 1'b1;
		o_mosi = ~o_mosi; // A released line must not look like held data.
		#(GAP_NS); // The gap keeps the idle time at six core clocks, one above the five needed.
	endtask : xfer

endmodule : spi_host_model

// file: test/status_reg_protect_and_busy_tb_top.sv
// Purpose : Self-checking bench for the first volatile status register block.
// Assumes : Host frames come from the serial host model.
// Notes   : Ordinary register writes run from a table; busy and reset cases follow.
`timescale 1ns/10ps

`define check(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
	$display("FAIL t=%0t got %h exp %h", $time, a, b); end end

module status_reg_protect_and_busy_tb_top;
	import flash_sr1_pkg::*;

	logic        i_mclk = 1'b0;
	logic        i_rst  = 1'b1;
	logic        i_wp_n = 1'b1;
	logic        i_quad_cmd_mode = 1'b0;
	logic        i_quad_io_mode  = 1'b0;
	byte_t       i_status_one_defaults = 8'h00;
	logic        i_target_protected = 1'b0;
	logic        i_op_fail = 1'b0;
	wire         cs_n, sck, mosi, miso, oe;
	logic        oe_seen = 1'b0;
	byte_t       sr, rd_v;
	logic        gran, origin;
	logic [2:0]  range_bits;
	logic        op_start, erase_err, prog_err, susp;
	op_kind_e    kind, last_kind;
	int          starts = 0;
	int          bad_count = 0;
	int          n_tests = 0;
	logic [27:0] r;
	// Rows: defaults, {wp_n, quad cmd, quad io, enable}, data, expected status.
	logic [27:0] rows [8] = '{28'h008FC00, 28'h0015F5C, 28'h80100DE, 28'h805A0A0,
		28'h8038080, 28'h8098D8C, 28'hA0800AC, 28'h2010808};

	// Core clock at 25 MHz.
	always #20 i_mclk = ~i_mclk;

	spi_host_model host (.i_miso(miso), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));

	status_reg_protect_and_busy dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_spi_sck(sck), .i_cs_n(cs_n), .i_mosi(mosi),
		.o_miso(miso), .o_miso_oe(oe), .i_wp_n(i_wp_n), .i_quad_cmd_mode(i_quad_cmd_mode),
		.i_quad_io_mode(i_quad_io_mode), .i_status_one_defaults(i_status_one_defaults),
		.i_target_protected(i_target_protected), .i_op_fail(i_op_fail),
		.o_status_one_volatile(sr), .o_protect_granularity_select(gran),
		.o_protect_origin_select(origin), .o_legacy_range_bits(range_bits),
		.o_op_start(op_start), .o_op_kind(kind), .o_erase_err(erase_err),
		.o_program_err(prog_err), .o_suspended(susp)
	);

	// Counts operation starts and keeps the kind of the latest one.
	always @(posedge i_mclk) begin
		if (op_start === 1'b1) begin
			starts    <= starts + 1;
			last_kind <= kind;
		end
	end

	// Notes that the block drove read data during a frame.
	always @(posedge sck) begin
		if (oe === 1'b1) begin
			oe_seen <= 1'b1;
		end
	end

	// Waits n core clocks and lands just after the edge.
	task automatic wt(input int n);
		repeat (n) @(posedge i_mclk);
		#2;
	endtask : wt

	// Sends a one byte command frame.
	task automatic cmd(input byte_t op);
		host.xfer({op, 32'h0}, 8, rd_v);
	endtask : cmd

	// Reads the status register over the link.
	task automatic rd_sr;
		host.xfer({OP_STATUS_READ_ONE, 32'h0}, 16, rd_v);
	endtask : rd_sr

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	// Cuts a hang short well after the expected run length.
	initial begin
		#400000;
		bad_count++;
		summarize();
	end

	// Main sequence.
	initial begin
		wt(20);
		i_rst = 1'b0;
		wt(6);
		foreach (rows[k]) begin
			r = rows[k];
			i_status_one_defaults = r[27:20];
			i_wp_n = r[19];
			i_quad_cmd_mode = r[18];
			i_quad_io_mode = r[17];
			wt(6);
			if (r[16]) cmd(OP_WRITE_ENABLE);
			host.xfer({OP_REGISTER_WRITE, r[15:8], 24'h0}, 16, rd_v);
			wt(40);
			rd_sr();
			`check(rd_v, r[7:0])
			`check(sr, r[7:0])
			`check({gran, origin, range_bits}, r[6:2])
			i_quad_cmd_mode = 1'b0;
			i_quad_io_mode = 1'b0;
		end
		`check(oe_seen, 1'b1)
		// A write disable sent while busy is ignored; completion clears the latch.
		cmd(OP_WRITE_ENABLE);
		host.xfer({OP_PAGE_PROGRAM, 32'h0}, 40, rd_v);
		cmd(OP_WRITE_DISABLE);
		rd_sr();
		`check(rd_v, 8'h0B)
		wt(40);
		`check(sr, 8'h08)
		`check(last_kind, KIND_PROG)
		// An erase of a protected target leaves the block busy until cleared.
		i_target_protected = 1'b1;
		cmd(OP_WRITE_ENABLE);
		host.xfer({OP_SECTOR_ERASE, 24'h0, 8'h0}, 32, rd_v);
		wt(40);
		`check(erase_err, 1'b1)
		`check(last_kind, KIND_ERASE)
		cmd(OP_WRITE_DISABLE);
		rd_sr();
		`check(rd_v, 8'h0B)
		i_target_protected = 1'b0;
		cmd(OP_CLEAR_STATUS);
		wt(4);
		`check({erase_err, prog_err, sr[1:0]}, 4'h0)
		cmd(OP_SUSPEND);
		wt(4);
		`check(susp, 1'b0)
		// Software reset reloads the fields and the latch from the defaults.
		cmd(OP_WRITE_ENABLE);
		host.xfer({OP_REGISTER_WRITE, 8'h5C, 24'h0}, 16, rd_v);
		wt(40);
		`check(sr, 8'h5C)
		i_status_one_defaults = 8'h22;
		wt(4);
		cmd(OP_RESET_ARM);
		cmd(OP_RESET_GO);
		wt(6);
		`check(sr, 8'h22)
		`check(starts, 8)
		// Locked with the pin low: other registers stay writable, this one does not.
		i_status_one_defaults = 8'hA2;
		wt(6);
		cmd(OP_WRITE_ENABLE);
		host.xfer({OP_ANY_REG_WRITE, 24'h000003, 8'hFC}, 40, rd_v);
		wt(40);
		`check(last_kind, KIND_OTHER)
		`check(sr, 8'hA0)
		cmd(OP_WRITE_ENABLE);
		host.xfer({OP_ANY_REG_WRITE, STATUS_ONE_VOLATILE_ADDR, 8'h00}, 40, rd_v);
		wt(40);
		`check(sr, 8'hA2)
		// Suspend during a program shows in the second status read; resume finishes it.
		host.xfer({OP_PAGE_PROGRAM, 32'h0}, 40, rd_v);
		cmd(OP_SUSPEND);
		`check(susp, 1'b1)
		host.xfer({OP_STATUS_READ_TWO, 32'h0}, 16, rd_v);
		`check(rd_v, 8'h01)
		cmd(OP_RESUME);
		wt(40);
		`check(susp, 1'b0)
		`check(sr, 8'hA0)
		`check(starts, 10)
		// Hardware reset in mid-run holds busy, then reloads the defaults.
		i_rst = 1'b1;
		wt(2);
		`check(sr, 8'h01)
		i_rst = 1'b0;
		wt(3);
		`check(sr, 8'hA2)
		summarize();
	end

endmodule : status_reg_protect_and_busy_tb_top
